// ### hw/mft_timer_two.sv
`timescale 1ns/100ps
`default_nettype none
module mft_timer_two
  import mft_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Timer pins
  input wire logic capture_in_one,
  input wire logic capture_in_two,
  input wire logic event_count_in,
  // Port read path
  input wire logic [7:0] port_pin_level,
  input wire logic [7:0] port_out_latch,
  output logic port_read_select,
  output logic [7:0] port_read_data,
  // Interrupt
  output logic irq
);

  // Flag update: hardware set wins over a software clear by writing zero
  function automatic logic next_flag(input logic cur, input logic set_ev,
                                     input logic wr, input logic wbit);
    next_flag = set_ev | (cur & ~(wr & ~wbit));
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] cur,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
    merge16 = {strb[1] ? data[15:8] : cur[15:8], strb[0] ? data[7:0] : cur[7:0]};
  endfunction

  mft_ctrl_a_t ctrl_a;
  mft_ctrl_b_t ctrl_b;
  logic [15:0] compare_reg_one;
  logic [15:0] compare_reg_two;
  logic [15:0] count;
  logic [15:0] capture_one_value;
  logic [15:0] capture_two_value;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic compare_two_active;
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;

  // Bus holding state
  logic aw_have;
  logic w_have;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_commit;
  logic rd_take;
  logic [31:0] next_rdata;
  logic next_rresp_err;

  // Event sources
  logic cap_one_edge;
  logic cap_two_edge;
  logic event_edge;
  logic pre_tick;
  logic advance;
  logic [15:0] next_count;
  logic cap_mode;
  logic cap_one_ev;
  logic cap_two_ev;
  logic cmp_one_ev;
  logic cmp_two_ev;
  logic ovf_ev;
  logic wr_ctrl_a;
  logic rd_clear_status;

  mft_edge u_cap_one (
    .mclk(mclk),
    .arst_n(arst_n),
    .pin(capture_in_one),
    .rising_sel(ctrl_b.capture_edge_select), // see R8
    .edge_pulse(cap_one_edge)
  );

  mft_edge u_cap_two (
    .mclk(mclk),
    .arst_n(arst_n),
    .pin(capture_in_two),
    .rising_sel(ctrl_b.capture_edge_select), // see R8
    .edge_pulse(cap_two_edge)
  );

  mft_edge u_event (
    .mclk(mclk),
    .arst_n(arst_n),
    .pin(event_count_in),
    .rising_sel(ctrl_b.event_edge_select), // see R9
    .edge_pulse(event_edge)
  );

  mft_prescale u_prescale (
    .mclk(mclk),
    .arst_n(arst_n),
    .prescale_field(ctrl_b.prescale_field),
    .tick(pre_tick)
  );

  // Mode decides what advances the counter and which events count
  always_comb begin
    case (ctrl_b.mode_field) // see R11
      MODE_SOFTWARE: advance = pre_tick;
      MODE_PWM: advance = pre_tick;
      MODE_CAPTURE: advance = pre_tick;
      MODE_EVENT: advance = event_edge;
      default: advance = 1'b0;
    endcase
  end

  assign cap_mode = (ctrl_b.mode_field == MODE_CAPTURE);
  assign next_count = count + 16'h0001;
  assign cap_one_ev = cap_mode & cap_one_edge;
  assign cap_two_ev = cap_mode & cap_two_edge;
  assign cmp_one_ev = advance & ~compare_two_active & (next_count == compare_reg_one);
  assign cmp_two_ev = advance & compare_two_active & (next_count == compare_reg_two);
  assign ovf_ev = advance & (count == COUNT_MAX);

  assign wr_commit = aw_have & w_have & ~s_axi_bvalid;
  assign rd_take = s_axi_arvalid & s_axi_arready;
  assign wr_ctrl_a = wr_commit & (aw_addr == ADDR_CTRL_A) & w_strb[0];
  assign rd_clear_status = rd_take & (s_axi_araddr[ADDR_MSB:ADDR_LSB] ==
                                      ADDR_IRQ_STATUS[ADDR_MSB:ADDR_LSB]);

  // Counter: wraps to zero after the top value
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      count <= 16'h0000;
    end else if (advance) begin
      count <= next_count; // see R10
    end
  end

  // Second compare register only takes turns in PWM mode
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      compare_two_active <= 1'b0;
    end else if (ctrl_b.mode_field != MODE_PWM) begin
      compare_two_active <= 1'b0;
    end else if (cmp_one_ev | cmp_two_ev) begin
      compare_two_active <= ~compare_two_active;
    end
  end

  // Captured counter values
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      capture_one_value <= 16'h0000;
      capture_two_value <= 16'h0000;
    end else begin
      if (cap_one_ev) begin
        capture_one_value <= count;
      end
      if (cap_two_ev) begin
        capture_two_value <= count;
      end
    end
  end

  // Control A: flags set by hardware, cleared by writing zero
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_a <= mft_ctrl_a_t'(CTRL_A_RESET);
    end else begin
      ctrl_a.capture_two_flag <= next_flag(ctrl_a.capture_two_flag, cap_two_ev,
                                           wr_ctrl_a, w_data[7]); // see R1
      ctrl_a.capture_one_flag <= next_flag(ctrl_a.capture_one_flag, cap_one_ev,
                                           wr_ctrl_a, w_data[6]); // see R2
      ctrl_a.compare_two_flag <= next_flag(ctrl_a.compare_two_flag, cmp_two_ev,
                                           wr_ctrl_a, w_data[4]); // see R4
      ctrl_a.compare_one_flag <= next_flag(ctrl_a.compare_one_flag, cmp_one_ev,
                                           wr_ctrl_a, w_data[3]); // see R5
      ctrl_a.overflow_flag <= next_flag(ctrl_a.overflow_flag, ovf_ev,
                                        wr_ctrl_a, w_data[1]); // see R6
      if (wr_ctrl_a) begin
        ctrl_a.capture_irq_enable <= w_data[5];
        ctrl_a.compare_irq_enable <= w_data[2];
        ctrl_a.overflow_irq_enable <= w_data[0];
      end
    end
  end

  // Other writable registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_b <= mft_ctrl_b_t'(CTRL_B_RESET);
      compare_reg_one <= CMP_RESET;
      compare_reg_two <= CMP_RESET;
      irq_mask <= IRQ_MASK_RESET;
    end else if (wr_commit) begin
      case (aw_addr)
        ADDR_CTRL_B: begin
          if (w_strb[0]) begin
            ctrl_b <= mft_ctrl_b_t'(w_data[7:0]);
          end
        end
        ADDR_CMP_ONE: compare_reg_one <= merge16(compare_reg_one, w_data, w_strb);
        ADDR_CMP_TWO: compare_reg_two <= merge16(compare_reg_two, w_data, w_strb);
        ADDR_IRQ_MASK: begin
          if (w_strb[0]) begin
            irq_mask <= w_data[2:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Sticky interrupt status, cleared by reading it; a new event wins
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_status <= 3'h0;
    end else begin
      irq_status[IRQ_CAPTURE] <= (ctrl_a.capture_irq_enable & (cap_one_ev | cap_two_ev))
                                 | (irq_status[IRQ_CAPTURE] & ~rd_clear_status); // see R3
      irq_status[IRQ_COMPARE] <= (ctrl_a.compare_irq_enable & (cmp_one_ev | cmp_two_ev))
                                 | (irq_status[IRQ_COMPARE] & ~rd_clear_status); // see R5
      irq_status[IRQ_OVERFLOW] <= (ctrl_a.overflow_irq_enable & ovf_ev)
                                  | (irq_status[IRQ_OVERFLOW] & ~rd_clear_status); // see R6
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // Port pins come from outside the clock domain
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
    end else begin
      pin_meta <= port_pin_level;
      pin_sync <= pin_meta;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      port_read_select <= 1'b0;
      port_read_data <= 8'h00;
    end else begin
      port_read_select <= ctrl_b.port_read_select;
      port_read_data <= ctrl_b.port_read_select ? port_out_latch : pin_sync; // see R7
    end
  end

  // Write channel: address and data held independently, any order
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      aw_have <= 1'b0;
      aw_addr <= 8'h00;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid & s_axi_awready) begin
      aw_have <= 1'b1;
      aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid & s_axi_bready) begin
      aw_have <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      w_have <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid & s_axi_wready) begin
      w_have <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid & s_axi_bready) begin
      w_have <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_commit) begin
      s_axi_bvalid <= 1'b1;
      case (aw_addr)
        ADDR_CTRL_A, ADDR_CTRL_B, ADDR_CMP_ONE, ADDR_CMP_TWO, ADDR_IRQ_MASK:
          s_axi_bresp <= RESP_OKAY;
        default: s_axi_bresp <= RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read data mux
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rresp_err = 1'b0;
    case ({s_axi_araddr[7:2], 2'b00})
      ADDR_CTRL_A: next_rdata[7:0] = ctrl_a;
      ADDR_CTRL_B: next_rdata[7:0] = ctrl_b;
      ADDR_CMP_ONE: next_rdata[15:0] = compare_reg_one;
      ADDR_CMP_TWO: next_rdata[15:0] = compare_reg_two;
      ADDR_COUNT: next_rdata[15:0] = count;
      ADDR_CAP_ONE: next_rdata[15:0] = capture_one_value;
      ADDR_CAP_TWO: next_rdata[15:0] = capture_two_value;
      ADDR_IRQ_STATUS: next_rdata[2:0] = irq_status;
      ADDR_IRQ_MASK: next_rdata[2:0] = irq_mask;
      ADDR_PORT_READ: next_rdata[7:0] = port_read_data;
      default: next_rresp_err = 1'b1;
    endcase
  end

  // Read channel: one read at a time, answer one cycle after the address
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // mft_timer_two
`default_nettype wire

// ### hw/mft_pkg.sv
// Operation
// R1: Capture two edge sets capture two flag
// R2: Capture one edge sets capture one flag
// R3: Capture enable raises interrupt per capture edge
// R4: Match on compare two sets its flag
// R5: Match on compare one sets flag, interrupt
// R6: Counter overflow sets flag, optional interrupt
// R7: Port reads return pins or output latches
// R8: Capture edge select picks rising or falling
// R9: Event edge select picks rising or falling
// R10: Prescaler divides clock by two to field
// R11: Mode field selects one of four modes
package mft_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL_A = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B = 8'h04;
  localparam logic [7:0] ADDR_CMP_ONE = 8'h08;
  localparam logic [7:0] ADDR_CMP_TWO = 8'h0c;
  localparam logic [7:0] ADDR_COUNT = 8'h10;
  localparam logic [7:0] ADDR_CAP_ONE = 8'h14;
  localparam logic [7:0] ADDR_CAP_TWO = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
  localparam logic [7:0] ADDR_PORT_READ = 8'h24;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_MSB = 7;

  // Reset values
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [7:0] CTRL_B_RESET = 8'h00;
  localparam logic [15:0] CMP_RESET = 16'hffff;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

  // Interrupt status bit positions
  localparam int IRQ_CAPTURE = 0;
  localparam int IRQ_COMPARE = 1;
  localparam int IRQ_OVERFLOW = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam int PRESCALE_BITS = 7;

  typedef enum logic [1:0] {
    MODE_SOFTWARE = 2'h0,
    MODE_PWM = 2'h1,
    MODE_CAPTURE = 2'h2,
    MODE_EVENT = 2'h3
  } mft_mode_t;

  // Bit 7 down to bit 0
  typedef struct packed {
    logic capture_two_flag;
    logic capture_one_flag;
    logic capture_irq_enable;
    logic compare_two_flag;
    logic compare_one_flag;
    logic compare_irq_enable;
    logic overflow_flag;
    logic overflow_irq_enable;
  } mft_ctrl_a_t;

  typedef struct packed {
    logic port_read_select;
    logic capture_edge_select;
    logic event_edge_select;
    logic [2:0] prescale_field;
    mft_mode_t mode_field;
  } mft_ctrl_b_t;

endpackage

// ### hw/mft_edge.sv
`timescale 1ns/100ps
`default_nettype none
// Two-stage synchroniser followed by a selectable edge detector
module mft_edge (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Pin and control
  input wire logic pin,
  input wire logic rising_sel,
  // Result
  output logic edge_pulse
);
  logic meta;
  logic sync;
  logic prev;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= pin;
      sync <= meta;
      prev <= sync;
    end
  end

  assign edge_pulse = rising_sel ? (sync & ~prev) : (~sync & prev);

endmodule // mft_edge
`default_nettype wire

// ### hw/mft_prescale.sv
`timescale 1ns/100ps
`default_nettype none
module mft_prescale
  import mft_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Divider select
  input wire logic [2:0] prescale_field,
  // One-cycle enable
  output logic tick
);
  logic [PRESCALE_BITS-1:0] div_count;
  logic [PRESCALE_BITS-1:0] div_mask;

  // Tick when the low field bits are all ones: divide by 2**field
  assign div_mask = PRESCALE_BITS'((8'h01 << prescale_field) - 8'h01);
  assign tick = ((div_count & div_mask) == div_mask); // see R10

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      div_count <= '0;
    end else begin
      div_count <= div_count + PRESCALE_BITS'(1);
    end
  end

endmodule // mft_prescale
`default_nettype wire

// ### bench/mft_pins_model.sv
`timescale 1ns/100ps
`default_nettype none
module mft_pins_model (
  // Clock
  input wire logic mclk,
  // Pins into the timer
  output logic capture_in_one,
  output logic capture_in_two,
  output logic event_count_in,
  output logic [7:0] port_pin_level
);
  initial begin
    capture_in_one = 1'b0;
    capture_in_two = 1'b0;
    event_count_in = 1'b0;
    port_pin_level = 8'ha5;
  end

  // Level then rest, long enough to cross the synchroniser and set a flag
  task automatic drive(input logic [1:0] which, input logic level);
    @(posedge mclk);
    case (which)
      2'h0: capture_in_one <= level;
      2'h1: capture_in_two <= level;
      default: event_count_in <= level;
    endcase
    repeat (6) @(posedge mclk);
  endtask
endmodule // mft_pins_model
`default_nettype wire

// ### bench/mft_timer_two_chk.sv
`timescale 1ns/100ps
`default_nettype none
module mft_timer_two_chk
  import mft_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  // Port read path
  input wire logic [7:0] port_pin_level,
  input wire logic [7:0] port_out_latch,
  input wire logic port_read_select,
  input wire logic [7:0] port_read_data
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Word compare: byte offsets inside the last word are still mapped
  sequence bad_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > ADDR_PORT_READ[7:2];
  endsequence
  // Two sync flops, the output register, two more for the edge leaving reset
  sequence pins_settled;
    (!port_read_select && $stable(port_pin_level))[*5];
  endsequence

  a_write_answer: assert property (aw_w_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not on time");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_ready_return: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
    else $error("write readies not back");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not on time");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_unmapped_read: assert property (bad_read |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_latch_read: assert property (port_read_select && $past(port_read_select) |->
    port_read_data == $past(port_out_latch))
    else $error("port read not from latch");
  a_pin_read: assert property (pins_settled |-> port_read_data == port_pin_level)
    else $error("port read not from pins");
endmodule // mft_timer_two_chk

bind mft_timer_two mft_timer_two_chk u_mft_timer_two_chk (
  .mclk(mclk), .arst_n(arst_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .port_pin_level(port_pin_level),
  .port_out_latch(port_out_latch), .port_read_select(port_read_select),
  .port_read_data(port_read_data)
);
`default_nettype wire

// ### bench/mft_timer_two_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module mft_timer_two_tb_top
  import mft_pkg::*;
;
  typedef struct {
    logic [7:0] a;
    logic [31:0] d;
    logic [3:0] s;
    logic [31:0] e;
    logic [1:0] r;
  } mft_row_t;
  // Upper lanes and unwritten lanes must be dropped
  mft_row_t rows [5] = '{
    '{ADDR_CMP_ONE, 32'hffff_1234, 4'hf, 32'h1234, RESP_OKAY},
    '{ADDR_CMP_ONE, 32'h5678, 4'h2, 32'h5634, RESP_OKAY},
    '{ADDR_CMP_TWO, 32'hbeef, 4'h3, 32'hbeef, RESP_OKAY},
    '{ADDR_IRQ_MASK, 32'hff, 4'h1, 32'h7, RESP_OKAY},
    '{8'h28, 32'h1, 4'hf, 32'h0, RESP_SLVERR}
  };
  logic mclk = 1'b0;
  logic arst_n, awv, wv, bv, bq, arv, rv, rq, c1, c2, ev, sel, irq;
  logic awq, wq, arq;
  logic [7:0] awa, ara, pins, lat, prd;
  logic [31:0] wd, rdat, rd_bus;
  logic [3:0] ws;
  logic [1:0] bresp, rresp, resp;
  logic [15:0] c0, dd;
  int cyc = 0;
  int miscompares = 0;
  int checked = 0;
  int t_rd, p, m, lo, hi, el;

  always #12.5 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;

  mft_timer_two u_mft_timer_two (
    .mclk(mclk), .arst_n(arst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awq),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wq),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bq), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arq), .s_axi_rdata(rd_bus), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rq), .capture_in_one(c1), .capture_in_two(c2),
    .event_count_in(ev), .port_pin_level(pins), .port_out_latch(lat),
    .port_read_select(sel), .port_read_data(prd), .irq(irq)
  );
  mft_pins_model u_mft_pins_model (
    .mclk(mclk), .capture_in_one(c1), .capture_in_two(c2), .event_count_in(ev),
    .port_pin_level(pins)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge mclk);
    awa <= a;
    wd <= d;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    bq <= 1'b1;
    do begin
      @(posedge mclk);
      if (awq) awv <= 1'b0;
      if (wq) wv <= 1'b0;
    end while (!bv);
    bq <= 1'b0;
    resp = bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    ara <= a;
    arv <= 1'b1;
    rq <= 1'b1;
    do begin
      @(posedge mclk);
      if (arq) arv <= 1'b0;
    end while (!rv);
    rq <= 1'b0;
    rdat = rd_bus;
    resp = rresp;
    t_rd = cyc;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdat, e);
  endtask

  task automatic end_of_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Sized for the overflow wait, the longest step
  initial begin
    repeat (90000) @(posedge mclk);
    miscompares++;
    end_of_test;
  end

  initial begin
    {arst_n, awv, wv, bq, arv, rq, awa, ara, wd} = '0;
    ws = 4'hf;
    lat = 8'h3c;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, rows[i].s);
      chk({30'h0, resp}, {30'h0, rows[i].r});
      rd(rows[i].a);
      chk(rdat, rows[i].e);
      chk({30'h0, resp}, {30'h0, rows[i].r});
    end
    @(posedge mclk);
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    rc(ADDR_CTRL_A, 32'h0);
    rc(ADDR_CTRL_B, 32'h0);
    rc(ADDR_CMP_ONE, 32'hffff);
    rc(ADDR_CMP_TWO, 32'hffff);
    rc(ADDR_IRQ_MASK, 32'h0);
    // Ticks over a span may round either way against the free divider
    for (int i = 0; i < 11; i++) begin
      p = (i < 8) ? i : 0;
      m = (i < 8) ? 0 : i - 7;
      wr(ADDR_CTRL_B, {27'h0, 3'(p), 2'(m)}, 4'h1);
      rd(ADDR_COUNT);
      c0 = rdat[15:0];
      el = t_rd;
      repeat (300) @(posedge mclk);
      rd(ADDR_COUNT);
      dd = rdat[15:0] - c0;
      lo = (m == 3) ? 0 : (t_rd - el) >> p;
      hi = (m == 3) ? 0 : lo + 1;
      chk({31'h0, dd >= 16'(lo) && dd <= 16'(hi)}, 32'h1);
    end
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTRL_B, {26'h0, ~i[1], 5'h03}, 4'h1);
      rd(ADDR_COUNT);
      c0 = rdat[15:0];
      u_mft_pins_model.drive(2'h2, ~i[0]);
      rd(ADDR_COUNT);
      chk({16'h0, rdat[15:0] - c0}, {31'h0, ~(i[0] ^ i[1])});
    end
    wr(ADDR_CTRL_B, 32'h42, 4'h1);
    wr(ADDR_IRQ_MASK, 32'h1, 4'h1);
    wr(ADDR_CTRL_A, 32'h20, 4'h1);
    u_mft_pins_model.drive(2'h0, 1'b1);
    rc(ADDR_CTRL_A, 32'h60);
    chk({31'h0, irq}, 32'h1);
    rc(ADDR_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    u_mft_pins_model.drive(2'h0, 1'b0);
    rc(ADDR_CTRL_A, 32'h60);
    wr(ADDR_CTRL_A, 32'h20, 4'h1);
    u_mft_pins_model.drive(2'h1, 1'b1);
    rc(ADDR_CTRL_A, 32'ha0);
    rc(ADDR_IRQ_STATUS, 32'h1);
    wr(ADDR_CTRL_B, 32'h02, 4'h1);
    wr(ADDR_CTRL_A, 32'h00, 4'h1);
    u_mft_pins_model.drive(2'h1, 1'b0);
    rc(ADDR_CTRL_A, 32'h80);
    rc(ADDR_IRQ_STATUS, 32'h0);
    wr(ADDR_CTRL_B, 32'h40, 4'h1);
    wr(ADDR_CTRL_A, 32'h00, 4'h1);
    u_mft_pins_model.drive(2'h0, 1'b1);
    rc(ADDR_CTRL_A, 32'h0);
    wr(ADDR_CTRL_B, 32'h01, 4'h1);
    wr(ADDR_IRQ_MASK, 32'h0, 4'h1);
    wr(ADDR_CTRL_A, 32'h04, 4'h1);
    rd(ADDR_COUNT);
    c0 = rdat[15:0];
    wr(ADDR_CMP_ONE, {16'h0, c0 + 16'h190}, 4'h3);
    wr(ADDR_CMP_TWO, {16'h0, c0 + 16'h320}, 4'h3);
    repeat (1000) @(posedge mclk);
    rc(ADDR_CTRL_A, 32'h1c);
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_IRQ_MASK, 32'h2, 4'h1);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    rc(ADDR_IRQ_STATUS, 32'h2);
    wr(ADDR_CTRL_B, 32'h00, 4'h1);
    wr(ADDR_CTRL_A, 32'h01, 4'h1);
    wr(ADDR_IRQ_MASK, 32'h4, 4'h1);
    rd(ADDR_COUNT);
    repeat (65586 - int'(rdat[15:0])) @(posedge mclk);
    rc(ADDR_CTRL_A, 32'h03);
    chk({31'h0, irq}, 32'h1);
    rc(ADDR_IRQ_STATUS, 32'h4);
    rc(ADDR_PORT_READ, 32'ha5);
    wr(ADDR_CTRL_B, 32'h80, 4'h1);
    repeat (3) @(posedge mclk);
    chk({31'h0, sel}, 32'h1);
    rc(ADDR_PORT_READ, 32'h3c);
    end_of_test;
  end
endmodule // mft_timer_two_tb_top
`default_nettype wire
